// ### verilog/urs_scr_fec.sv
// Transmit scrambler/hopping generator and RS(63,55) plus inner convolutional encoder
//
// Contract
// - Chip scrambling code and hop positions both come from one shared PRBS.
// - Fifteen-stage LFSR, each output is XOR of outputs 14 and 15 earlier.
// - LFSR loads its initial state when header bit 0 goes out.
// - After the header the LFSR runs on through payload without reset.
// - Seed is preamble code with zeros dropped, -1 as 0, first 15 bits.
// - LFSR steps exactly chips-per-burst times per symbol, even below hop width.
// - Hop index is first m outputs of a symbol, earliest bit LSB.
// - 15.60 MHz mode uses 3 hop bits, 3.90 MHz mode uses 5.
// - FEC is outer RS then inner half-rate code, bypassed at rate one.
// - RS stage appends 48 parity bits after the M data bits.
// - Rate half gives 2M+100 bits, systematic to position, parity to polarity.
// - Rate one sends even-indexed RS output bits to polarity; M is even.
// - Field is GF(2^6) from primitive polynomial 1+x+x^6.
// - Generator is monic degree 8 with coefficients 55,61,37,48,47,20,6,22.
// - Block of I bits gets 330-I leading zero bits.
// - 330 bits form 55 six-bit symbols, earliest bit LSB.
// - Codeword is 55 data symbols then 8 parity symbols, earliest highest power.
// - The 63 symbols serialise LSB first into 378 bits.
// - Padding is dropped, only the last I+48 bits are emitted.
// - Inner code taps 010 and 101, zero start, flushed by two zeros.
module urs_scr_fec #(
  parameter int NCPB_W = 10
) (
  input wire logic clk, // 40 MHz system clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic hdr_start, // Pulse: header bit 0 going out
  input wire urs_pkg::urs_code_t pre_code, // Active ternary preamble code
  input wire logic sym_start, // Pulse: begin one symbol of chips
  input wire logic [NCPB_W-1:0] ncpb, // Chips per burst for this symbol
  input wire logic prf_low, // 1: 3.90 MHz mean rate, 0: 15.60 MHz
  output logic chip_bit, // Scrambler output for this chip
  output logic chip_valid, // One cycle per chip
  output logic sym_busy, // Symbol stepping in progress
  output logic [urs_pkg::HOP_W-1:0] hop_idx, // Hop position of last symbol
  output logic hop_valid, // Pulse: hop_idx updated
  input wire logic blk_start, // Pulse: new FEC block, length valid
  input wire logic [urs_pkg::LEN_W-1:0] blk_len, // Payload bits I, at most 330
  input wire logic vit_rate_one, // 1: inner encoder bypassed
  input wire logic in_bit, // Payload bit
  input wire logic in_valid, // Payload bit present
  output logic in_ready, // Payload bit accepted when valid
  output urs_pkg::urs_fec_t fec_out, // Position and polarity bits
  output logic fec_valid, // Pulse: fec_out is new
  output logic fec_done // Pulse: last output of the block
);
  import urs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Types and declarations

  typedef enum {F_IDLE, F_DATA, F_PAR, F_FLUSH} urs_fst_t;

  logic [SCR_STAGES-1:0] lfsr;
  logic [NCPB_W-1:0] chip_left;
  logic [NCPB_W-1:0] chip_idx;
  logic [2:0] hop_m;
  logic [HOP_W-1:0] hop_acc;
  logic [HOP_W-1:0] next_hop;
  logic scr_out;
  logic scr_step;
  logic scr_last;

  urs_fst_t fstate;
  urs_fst_t next_fstate;
  logic [LEN_W-1:0] bit_pos;
  logic [2:0] sub;
  logic [5:0] acc;
  logic [5:0] next_acc;
  logic [7:0][5:0] par;
  logic [7:0][5:0] next_par;
  logic [5:0] fb;
  logic [2:0] pbit;
  logic [2:0] psym;
  logic fl_cnt;
  logic rate1;
  logic [1:0] conv_sh;
  logic half;
  logic even_hold;
  logic take;
  logic sym_done;
  logic last_data;
  logic last_par;
  logic rs_go;
  logic rs_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Seed derivation from the ternary preamble code

  // Walk the code, skip zeros, keep the first 15 nonzero chips
  function automatic logic [SCR_STAGES-1:0] seed_of(input urs_code_t c);
    logic [SCR_STAGES-1:0] s;
    int n;
    s = '0;
    n = 0;
    for (int i = 0; i < PRE_CODE_LEN; i++) begin
      if ((c.pos[i] || c.neg[i]) && n < SCR_STAGES) begin
        // -1 maps to 0, +1 maps to 1; oldest stage gets the first one
        s[n] = c.pos[i];
        n = n + 1;
      end
    end
    return s;
  endfunction : seed_of

  ////////////////////////////////////////////////////////////////////////////
  // Scrambler

  // lfsr[0] is the oldest output, lfsr[14] the newest
  // feedback taps
  assign scr_out = lfsr[0] ^ lfsr[1];
  assign scr_step = chip_left != '0;
  assign scr_last = chip_left == NCPB_W'(1);

  // no other reload, payload continues the same sequence
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lfsr <= SCR_RESET;
    end else if (hdr_start) begin
      lfsr <= seed_of(pre_code);
    end else if (scr_step) begin
      lfsr <= {scr_out, lfsr[SCR_STAGES-1:1]};
    end
  end

  // step count per symbol is ncpb, never stretched to the hop width
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chip_left <= '0;
      chip_idx <= '0;
    end else if (hdr_start) begin
      chip_left <= '0;
      chip_idx <= '0;
    end else if (sym_start && !scr_step) begin
      chip_left <= ncpb;
      chip_idx <= '0;
    end else if (scr_step) begin
      chip_left <= chip_left - NCPB_W'(1);
      chip_idx <= chip_idx + NCPB_W'(1);
    end
  end

  // the same output bit feeds the chip code and the hop index
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chip_bit <= 1'b0;
      chip_valid <= 1'b0;
      sym_busy <= 1'b0;
    end else begin
      chip_bit <= scr_out;
      chip_valid <= scr_step && !hdr_start;
      sym_busy <= !hdr_start && ((sym_start && !scr_step && ncpb != '0) ||
                                 (scr_step && !scr_last));
    end
  end

  // earliest output goes to the hop LSB
  always_comb begin
    next_hop = hop_acc;
    if (chip_idx < NCPB_W'(hop_m)) begin
      next_hop[chip_idx[2:0]] = scr_out;
    end
  end

  // hop width picked by mean rate, latched per symbol
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hop_m <= HOP_M_HI;
      hop_acc <= '0;
    end else if (sym_start && !scr_step) begin
      hop_m <= prf_low ? HOP_M_LO : HOP_M_HI;
      hop_acc <= '0;
    end else if (scr_step) begin
      hop_acc <= next_hop;
    end
  end

  // Short symbols leave the unfilled hop bits at zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hop_idx <= '0;
      hop_valid <= 1'b0;
    end else begin
      hop_valid <= scr_step && scr_last && !hdr_start;
      if (scr_step && scr_last && !hdr_start) begin
        hop_idx <= next_hop;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reed-Solomon encoder control

  // source holds in_bit until in_ready and in_valid meet
  assign take = (fstate == F_DATA) && in_valid && in_ready;
  assign sym_done = take && (sub == SYM_MSB);
  assign last_data = take && (bit_pos == RS_LAST_POS);
  assign last_par = (fstate == F_PAR) && (pbit == SYM_MSB) && (psym == RS_NPAR_LAST);

  // Block sequencing; a start while busy or with length above 330 is ignored
  always_comb begin
    next_fstate = fstate;
    case (fstate)
      F_IDLE: begin
        if (blk_start && blk_len <= RS_PAD_BITS) begin
          next_fstate = (blk_len == '0) ? F_PAR : F_DATA;
        end
      end
      F_DATA: begin
        if (last_data) begin
          next_fstate = F_PAR;
        end
      end
      F_PAR: begin
        if (last_par) begin
          next_fstate = rate1 ? F_IDLE : F_FLUSH;
        end
      end
      F_FLUSH: begin
        if (fl_cnt == FLUSH_LAST) begin
          next_fstate = F_IDLE;
        end
      end
      default: begin
        next_fstate = F_IDLE;
      end
    endcase
  end

  // Registered ready so the source sees a clean level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fstate <= F_IDLE;
      in_ready <= 1'b0;
    end else begin
      fstate <= next_fstate;
      in_ready <= next_fstate == F_DATA;
    end
  end

  // leading zeros are never clocked in, only skipped in the position count
  // bit position within a symbol starts at (330-I) mod 6
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_pos <= '0;
      sub <= '0;
      rate1 <= 1'b0;
    end else if (fstate == F_IDLE && blk_start && blk_len <= RS_PAD_BITS) begin
      bit_pos <= RS_PAD_BITS - blk_len;
      sub <= 3'((RS_PAD_BITS - blk_len) % SYM_BITS);
      rate1 <= vit_rate_one;
    end else if (take) begin
      bit_pos <= bit_pos + LEN_W'(1);
      sub <= (sub == SYM_MSB) ? 3'h0 : sub + 3'h1;
    end
  end

  // earliest bit of a symbol lands in the LSB
  always_comb begin
    next_acc = acc;
    if (take) begin
      next_acc[sub] = in_bit;
    end
  end

  // Padding zeros already sit in a cleared accumulator
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc <= '0;
    end else if (fstate == F_IDLE) begin
      acc <= '0;
    end else if (sym_done) begin
      acc <= '0;
    end else if (take) begin
      acc <= next_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reed-Solomon parity division

  // generator coefficients drive the feedback products
  // remainder of x^8 D(x) by g(x), earliest symbol highest power
  always_comb begin
    fb = next_acc ^ par[7];
    next_par[0] = urs_gf_mul(fb, RS_GEN[0]);
    for (int i = 1; i < 8; i++) begin
      next_par[i] = par[i-1] ^ urs_gf_mul(fb, RS_GEN[i]);
    end
  end

  // Leading zero symbols leave a zero register unchanged, so they are skipped
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      par <= '0;
      pbit <= '0;
      psym <= '0;
    end else if (fstate == F_IDLE) begin
      par <= '0;
      pbit <= '0;
      psym <= '0;
    end else if (sym_done) begin
      par <= next_par;
    end else if (fstate == F_PAR) begin
      // parity symbols leave LSB first, x^7 term first
      if (pbit == SYM_MSB) begin
        par <= {par[6:0], 6'h00};
        pbit <= '0;
        psym <= psym + 3'h1;
      end else begin
        pbit <= pbit + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RS output stream

  // data bits go out as taken, so padding never appears
  // 48 parity bits follow the data
  always_comb begin
    rs_go = 1'b0;
    rs_bit = 1'b0;
    case (fstate)
      F_DATA: begin
        rs_go = take;
        rs_bit = in_bit;
      end
      F_PAR: begin
        rs_go = 1'b1;
        rs_bit = par[7][pbit];
      end
      F_FLUSH: begin
        rs_go = 1'b1;
        rs_bit = 1'b0;
      end
      default: begin
        rs_go = 1'b0;
        rs_bit = 1'b0;
      end
    endcase
  end

  // Flush counter only runs at rate half
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fl_cnt <= 1'b0;
    end else if (fstate == F_FLUSH) begin
      fl_cnt <= ~fl_cnt;
    end else begin
      fl_cnt <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inner encoder and rate-one multiplexer

  // rate one bypasses the convolutional stage
  // systematic bit to position, u(k) xor u(k-2) to polarity
  // at rate one even bits drive polarity, odd bits position
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_sh <= 2'h0;
      half <= 1'b0;
      even_hold <= 1'b0;
      fec_out <= '0;
      fec_valid <= 1'b0;
    end else if (fstate == F_IDLE) begin
      // zero state at every block start
      conv_sh <= 2'h0;
      half <= 1'b0;
      fec_valid <= 1'b0;
    end else if (rs_go && !rate1) begin
      fec_out.pos <= rs_bit;
      fec_out.pol <= rs_bit ^ conv_sh[1];
      fec_valid <= 1'b1;
      conv_sh <= {conv_sh[0], rs_bit};
    end else if (rs_go) begin
      // M even and 48 parity keep the pairs aligned
      if (!half) begin
        even_hold <= rs_bit;
        half <= 1'b1;
        fec_valid <= 1'b0;
      end else begin
        fec_out.pos <= rs_bit;
        fec_out.pol <= even_hold;
        half <= 1'b0;
        fec_valid <= 1'b1;
      end
    end else begin
      fec_valid <= 1'b0;
    end
  end

  // End of block marker, in step with the last fec_valid
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fec_done <= 1'b0;
    end else begin
      fec_done <= ((fstate == F_FLUSH) && (fl_cnt == FLUSH_LAST)) || (last_par && rate1);
    end
  end

endmodule : urs_scr_fec

// ### verilog/urs_pkg.sv
// Shared constants, types and field arithmetic for the scrambler and RS/conv encoder
package urs_pkg;

  // Scrambler: 15 stages, taps at delays 14 and 15
  localparam int SCR_STAGES = 15;
  localparam int PRE_CODE_LEN = 31;
  localparam logic [14:0] SCR_RESET = 15'h0000;
  // Peak chip rate in kHz; one LFSR step per enabled clock stands in for one chip
  localparam int CHIP_RATE_KHZ = 499200;

  // Hop index widths: 8 positions at 15.60 MHz, 32 at 3.90 MHz mean rate
  localparam logic [2:0] HOP_M_HI = 3'h3;
  localparam logic [2:0] HOP_M_LO = 3'h5;
  localparam int HOP_W = 5;

  // Reed-Solomon shortened block geometry
  localparam int LEN_W = 9;
  localparam logic [8:0] RS_PAD_BITS = 9'h014a;
  localparam logic [8:0] RS_LAST_POS = 9'h0149;
  localparam logic [8:0] SYM_BITS = 9'h0006;
  localparam logic [2:0] SYM_MSB = 3'h5;
  localparam logic [2:0] RS_NPAR_LAST = 3'h7;
  localparam int RS_PAR_BITS = 48;

  // GF(2^6) from 1+x+x^6: x^6 folds back to x+1
  localparam logic [5:0] GF_RED = 6'h03;

  // Monic generator, coefficients of x^7 down to x^0
  localparam logic [7:0][5:0] RS_GEN = {6'h37, 6'h3d, 6'h25, 6'h30, 6'h2f, 6'h14, 6'h06, 6'h16};

  // Inner code flush length
  localparam logic FLUSH_LAST = 1'h1;

  // Ternary preamble code: a set bit in pos is +1, in neg is -1, neither is 0
  typedef struct packed {
    logic [PRE_CODE_LEN-1:0] pos;
    logic [PRE_CODE_LEN-1:0] neg;
  } urs_code_t;

  // One modulator symbol: burst position bit and polarity bit
  typedef struct packed {
    logic pos;
    logic pol;
  } urs_fec_t;

  // Field multiply, shift-and-add with reduction
  function automatic logic [5:0] urs_gf_mul(input logic [5:0] a, input logic [5:0] b);
    logic [5:0] acc;
    logic [5:0] sh;
    acc = '0;
    sh = a;
    for (int i = 0; i < 6; i++) begin
      if (b[i]) begin
        acc = acc ^ sh;
      end
      sh = sh[5] ? ({sh[4:0], 1'b0} ^ GF_RED) : {sh[4:0], 1'b0};
    end
    return acc;
  endfunction : urs_gf_mul

endpackage : urs_pkg

// ### dv/urs_scr_fec_chk.sv
// Port checker for the scrambler and RS/convolutional encoder, with its bind
module urs_scr_fec_chk #(
  parameter int NCPB_W = 10
) (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic hdr_start, // Header start
  input wire logic sym_start, // Symbol start
  input wire logic [NCPB_W-1:0] ncpb, // Chips per burst
  input wire logic prf_low, // Low rate mode
  input wire logic chip_valid, // Chip strobe
  input wire logic sym_busy, // Symbol running
  input wire logic [urs_pkg::HOP_W-1:0] hop_idx, // Hop index
  input wire logic hop_valid, // Hop strobe
  input wire logic blk_start, // Block start
  input wire logic [urs_pkg::LEN_W-1:0] blk_len, // Length
  input wire logic vit_rate_one, // Bypass
  input wire logic in_bit, // Payload bit
  input wire logic in_valid, // Bit present
  input wire logic in_ready, // Bit taken
  input wire urs_pkg::urs_fec_t fec_out, // Encoded pair
  input wire logic fec_valid, // Pair strobe
  input wire logic fec_done // Last pair
);
  import urs_pkg::*;
  logic blk_act; // Block in progress
  logic rate_one; // Bypass of that block
  logic [9:0] blk_i; // Its length
  logic [9:0] out_cnt; // Pairs so far
  logic [9:0] exp_cnt; // Pairs due
  logic sym_go; // Symbol that must start
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // Mirror of block state, since idle is not visible at the ports
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_act <= 1'b0;
      rate_one <= 1'b0;
      blk_i <= 10'h000;
      out_cnt <= 10'h000;
    end else if (blk_start && !blk_act && blk_len <= RS_PAD_BITS) begin
      blk_act <= 1'b1;
      rate_one <= vit_rate_one;
      blk_i <= {1'b0, blk_len};
      out_cnt <= 10'h000;
    end else begin
      if (fec_done) begin
        blk_act <= 1'b0;
      end
      if (fec_valid) begin
        out_cnt <= out_cnt + 10'h001;
      end
    end
  end
  // Flush adds two pairs; bypass halves the RS bit count
  assign exp_cnt = rate_one ? ((blk_i + 10'h030) >> 1) : (blk_i + 10'h032);
  assign sym_go = sym_start && !hdr_start && !sym_busy && !chip_valid && ncpb != '0;
  // Start edge loads the count, first step is one edge later, strobe is registered
  sym_starts_a: assert property (sym_go |=> ##1 chip_valid)
    else $error("symbol gave no chip");
  sym_single_a: assert property (sym_go && ncpb == 1 |=> ##1 (chip_valid && hop_valid))
    else $error("one-chip symbol wrong");
  sym_three_a: assert property (sym_go && ncpb == 3 |=>
    ##1 (chip_valid && !hop_valid) [*2] ##1 (chip_valid && hop_valid) ##1 !chip_valid)
    else $error("three-chip symbol wrong");
  hop_chip_a: assert property (hop_valid |-> chip_valid)
    else $error("hop without chip");
  hop_hold_a: assert property ($changed(hop_idx) |-> hop_valid)
    else $error("hop index moved");
  hop_narrow_a: assert property (hop_valid && !prf_low |-> hop_idx[4:3] == 2'h0)
    else $error("hop index too wide");
  hdr_abort_a: assert property (hdr_start |=> !sym_busy && !hop_valid)
    else $error("reload did not abort");
  blk_take_a: assert property (blk_start && !blk_act && blk_len != '0 &&
    blk_len <= RS_PAD_BITS |=> in_ready)
    else $error("block not taken");
  blk_refuse_a: assert property (blk_start && !blk_act && blk_len > RS_PAD_BITS
    |=> !in_ready && !fec_valid)
    else $error("long block taken");
  sys_pos_a: assert property (in_valid && in_ready && !rate_one |=>
    fec_valid && fec_out.pos == $past(in_bit))
    else $error("position bit wrong");
  out_count_a: assert property (fec_done |-> fec_valid && out_cnt + 10'h001 == exp_cnt)
    else $error("block output count wrong");
  cover property (hop_valid && prf_low);
  cover property (fec_done && rate_one);
  cover property (fec_done && !rate_one);
endmodule : urs_scr_fec_chk

bind urs_scr_fec urs_scr_fec_chk #(.NCPB_W(NCPB_W)) u_chk (.clk(clk), .sys_rst(sys_rst),
  .hdr_start(hdr_start), .sym_start(sym_start), .ncpb(ncpb), .prf_low(prf_low),
  .chip_valid(chip_valid), .sym_busy(sym_busy), .hop_idx(hop_idx), .hop_valid(hop_valid),
  .blk_start(blk_start), .blk_len(blk_len), .vit_rate_one(vit_rate_one), .in_bit(in_bit),
  .in_valid(in_valid), .in_ready(in_ready), .fec_out(fec_out), .fec_valid(fec_valid),
  .fec_done(fec_done));

// ### dv/urs_frame_end.sv
// Frame source and burst modulator sink around the encoder
module urs_frame_end (
  input wire logic clk, // Clock
  input wire logic in_ready, // Bit taken
  input wire urs_pkg::urs_fec_t fec_out, // Encoded pair
  input wire logic fec_valid, // Pair strobe
  output logic in_bit, // Payload bit
  output logic in_valid // Bit present
);
  import urs_pkg::*;
  urs_fec_t cap[$]; // Pairs the modulator took
  ////////////////////////////////////////////////////////////
  // modulator takes every strobe
  always @(posedge clk) begin
    if (fec_valid) begin
      cap.push_back(fec_out);
    end
  end
  // bits held until taken, line scrambled between
  task automatic send(input logic [329:0] d, input int n, input int gap);
    int k;
    for (int t = 0; t < n; t++) begin
      repeat (gap) begin
        in_valid = 1'b0;
        in_bit = ~in_bit;
        @(posedge clk);
        #2;
      end
      in_valid = 1'b1;
      in_bit = d[t];
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (in_ready !== 1'b1 && k < 200);
      #2;
    end
    in_valid = 1'b0;
    in_bit = ~in_bit;
  endtask : send
  // Idle at time zero
  initial begin
    in_bit = 1'b0;
    in_valid = 1'b0;
  end
endmodule : urs_frame_end

// ### dv/test_uwb_scrambler_rs_fec_encoder.sv
// Self-checking bench for the scrambler, hop generator and RS/convolutional encoder
module test_uwb_scrambler_rs_fec_encoder;
  timeunit 1ns;
  timeprecision 100ps;
  import urs_pkg::*;
  localparam logic [14:0] SEED6 = 15'h716d; // Seed of the example code
  logic clk, sys_rst, hdr_start, sym_start, prf_low, chip_bit, chip_valid, sym_busy;
  logic hop_valid, blk_start, vit_rate_one, in_bit, in_valid, in_ready, fec_valid, fec_done;
  logic [9:0] ncpb;
  logic [4:0] hop_idx;
  logic [8:0] blk_len;
  logic [14:0] hist; // Reference history, bit 0 newest
  urs_code_t pre_code;
  urs_fec_t fec_out;
  int failures = 0;
  int num_checks = 0;
  urs_scr_fec u_dut (.clk(clk), .sys_rst(sys_rst), .hdr_start(hdr_start), .pre_code(pre_code),
    .sym_start(sym_start), .ncpb(ncpb), .prf_low(prf_low), .chip_bit(chip_bit),
    .chip_valid(chip_valid), .sym_busy(sym_busy), .hop_idx(hop_idx), .hop_valid(hop_valid),
    .blk_start(blk_start), .blk_len(blk_len), .vit_rate_one(vit_rate_one), .in_bit(in_bit),
    .in_valid(in_valid), .in_ready(in_ready), .fec_out(fec_out), .fec_valid(fec_valid),
    .fec_done(fec_done));
  urs_frame_end u_end (.clk(clk), .in_ready(in_ready), .fec_out(fec_out),
    .fec_valid(fec_valid), .in_bit(in_bit), .in_valid(in_valid));
  ////////////////////////////////////////////////////////////
  // 40 MHz clock
  always #12.5 clk = ~clk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk);
    #2;
  endtask : tick
  task automatic give_up(input string what);
    failures++;
    $display("MISMATCH %s expected 1 seen 0", what);
    end_sim();
  endtask : give_up
  // Horner multiply, x^6 folds to x+1
  function automatic logic [5:0] gmul(input logic [5:0] a, input logic [5:0] b);
    logic [5:0] acc;
    acc = 6'h00;
    for (int i = 5; i >= 0; i--) begin
      acc = {acc[4:0], 1'b0} ^ (acc[5] ? 6'h03 : 6'h00) ^ (b[i] ? a : 6'h00);
    end
    return acc;
  endfunction : gmul
  // One symbol against the reference generator
  task automatic run_sym(input int n, input logic lo);
    logic [4:0] hop;
    logic nb;
    int k;
    hop = 5'h00;
    sym_start = 1'b1;
    ncpb = n[9:0];
    prf_low = lo;
    tick();
    sym_start = 1'b0;
    for (int j = 0; j < n; j++) begin
      k = 0;
      while (chip_valid !== 1'b1) begin
        tick();
        if (++k > 9) give_up("chip_valid");
      end
      nb = hist[13] ^ hist[14];
      hist = {hist[13:0], nb};
      if (j < (lo ? 5 : 3)) hop[j] = nb;
      chk("chip_bit", nb, chip_bit);
      chk("hop_valid", j == n - 1, hop_valid);
      chk("sym_busy", j < n - 1, sym_busy);
      tick();
    end
    chk("chip_valid", 0, chip_valid);
    chk("hop_idx", hop, hop_idx);
  endtask : run_sym
  // Code with zeros between elements and a sixteenth nonzero element
  task automatic t_seed();
    for (int j = 0; j < 15; j++) begin
      pre_code.pos[2 * j + 1] = SEED6[14 - j];
      pre_code.neg[2 * j + 1] = !SEED6[14 - j];
    end
    pre_code.neg[30] = 1'b1;
    hdr_start = 1'b1;
    tick();
    hdr_start = 1'b0;
    hist = SEED6;
    run_sym(16, 1'b1);
    run_sym(3, 1'b0);
    run_sym(1, 1'b0);
    run_sym(2, 1'b1);
    $display("test seed done");
  endtask : t_seed
  // Early request ignored, then reload cuts a long symbol short
  task automatic t_abort();
    sym_start = 1'b1;
    ncpb = 10'h028;
    tick();
    sym_start = 1'b0;
    tick();
    sym_start = 1'b1;
    tick();
    sym_start = 1'b0;
    hdr_start = 1'b1;
    tick();
    hdr_start = 1'b0;
    tick();
    tick();
    chk("chip_valid", 0, chip_valid);
    chk("sym_busy", 0, sym_busy);
    hist = SEED6;
    run_sym(16, 1'b1);
    $display("test abort done");
  endtask : t_abort
  // One block through the source and sink against the reference code
  task automatic run_blk(input int n, input logic r1, input int gap);
    logic [329:0] d, p;
    logic [377:0] u;
    logic [5:0] r[8];
    logic [5:0] fb;
    urs_fec_t e;
    int cnt, k;
    d = {11{30'h2b5c_19e7}} ^ (330'(n) << 5);
    p = d << (330 - n);
    r = '{default: 6'h00};
    for (int s = 0; s < 55; s++) begin
      fb = p[6 * s +: 6] ^ r[7];
      for (int i = 7; i > 0; i--) r[i] = r[i - 1] ^ gmul(fb, RS_GEN[i]);
      r[0] = gmul(fb, RS_GEN[0]);
    end
    u = '0;
    for (int t = 0; t < n; t++) u[t] = d[t];
    for (int i = 0; i < 48; i++) u[n + i] = r[7 - i / 6][i % 6];
    u_end.cap.delete();
    blk_start = 1'b1;
    blk_len = n[8:0];
    vit_rate_one = r1;
    tick();
    blk_start = 1'b0;
    fork
      u_end.send(d, n, gap);
    join_none
    k = 0;
    while (fec_done !== 1'b1) begin
      tick();
      if (++k > 1500) give_up("fec_done");
    end
    tick();
    cnt = r1 ? (n + 48) / 2 : n + 50;
    chk("fec count", cnt, u_end.cap.size());
    for (int j = 0; j < cnt; j++) begin
      e.pos = r1 ? u[2 * j + 1] : u[j];
      e.pol = r1 ? u[2 * j] : u[j] ^ (j > 1 ? u[j - 2] : 1'b0);
      chk("fec_out", e, u_end.cap[j]);
    end
  endtask : run_blk
  task automatic t_fec_half();
    run_blk(6, 1'b0, 0);
    run_blk(0, 1'b0, 0);
    $display("test fec half done");
  endtask : t_fec_half
  task automatic t_fec_one();
    run_blk(330, 1'b1, 0);
    run_blk(100, 1'b1, 2);
    $display("test fec one done");
  endtask : t_fec_one
  // Length above the padded size is refused
  task automatic t_refuse();
    blk_start = 1'b1;
    blk_len = 9'h14b;
    tick();
    blk_start = 1'b0;
    repeat (4) begin
      tick();
      chk("in_ready", 0, in_ready);
    end
    run_blk(12, 1'b0, 1);
    $display("test refuse done");
  endtask : t_refuse
  // Reset held 20 cycles, then the scenarios
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    hdr_start = 1'b0;
    sym_start = 1'b0;
    prf_low = 1'b0;
    ncpb = 10'h000;
    blk_start = 1'b0;
    blk_len = 9'h000;
    vit_rate_one = 1'b0;
    pre_code = '0;
    repeat (20) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    t_seed();
    t_abort();
    t_fec_half();
    t_fec_one();
    t_refuse();
    end_sim();
  end
endmodule : test_uwb_scrambler_rs_fec_encoder
